// ### ebl_pkg.sv
// shared constants for the eeprom boot loader
// Notes on behaviour
// - first block address is 0x80 times pins
// - options field picks configuration or boot table
// - options 01 means boot table load
// - options 02 means boot configuration load
// - after configuration, chain to next-address fields
// - source: offset 8 address, offset 10 device
// - eeprom content laid out in 128-byte blocks
// - bus divider from offsets 16 and 18
// - first table word is entry address
// - section: count, destination, then data bytes
// - zero count ends table, then branch
// - no parameter sets read after table
// - configuration applied before any application copy
// - config entry: target, set, clear; both toggles
// - all-zero config entry ends configuration
package ebl_pkg;
  // parameter block layout, byte offsets of 16-bit fields
  localparam logic [15:0] BLOCK_STRIDE = 16'h0080;
  localparam logic [4:0] PARAM_BYTES = 5'h18;
  localparam logic [4:0] OFS_OPTIONS = 5'h06;
  localparam logic [4:0] OFS_DEV_LO = 5'h08;
  localparam logic [4:0] OFS_DEV_HI = 5'h0a;
  localparam logic [4:0] OFS_CPU_MHZ = 5'h10;
  localparam logic [4:0] OFS_I2C_KHZ = 5'h12;
  localparam logic [4:0] OFS_NEXT_LO = 5'h14;
  localparam logic [4:0] OFS_NEXT_HI = 5'h16;
  localparam logic [4:0] HALF_STEP = 5'h02;
  // options encodings
  localparam logic [15:0] OPT_TABLE = 16'h0001;
  localparam logic [15:0] OPT_CFG = 16'h0002;
  // default eeprom bus address
  localparam logic [6:0] DEF_DEV = 7'h50;
  // transfer sizes
  localparam logic [2:0] HALF_BYTES = 3'h2;
  localparam logic [2:0] WORD_BYTES = 3'h4;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  // bus timing: four quarter phases per scl period
  localparam int CLOCK_MHZ = 250;
  localparam int DEF_I2C_KHZ = 100;
  localparam logic [31:0] KHZ_SCALE = 32'h0000_00fa;
  localparam logic [15:0] DEF_QUARTER = 16'(CLOCK_MHZ * 250 / DEF_I2C_KHZ);
  localparam logic [1:0] Q_SETUP = 2'h0;
  localparam logic [1:0] Q_RISE = 2'h1;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_FALL = 2'h3;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // header byte sequence of a random read
  localparam logic [1:0] HDR_DEVW = 2'h0;
  localparam logic [1:0] HDR_AHI = 2'h1;
  localparam logic [1:0] HDR_ALO = 2'h2;
  localparam logic [1:0] HDR_DEVR = 2'h3;
  // pin settle cycles before the select pins are trusted
  localparam logic [1:0] SYNC_WAIT = 2'h3;
endpackage

// ### ebl_fifo.sv
// small flop fifo between the bus engine and the loader
`timescale 1ns/1ps
`default_nettype none
module ebl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ebl_fifo_state_t;
  ebl_fifo_state_t r, next_r;
  logic push, pop;
  assign in_ready = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // pointers wrap naturally, so depth must be a power of two
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = in_data;
      next_r.wp = AW'(r.wp + 1'b1);
    end
    if (pop) begin
      next_r.rp = AW'(r.rp + 1'b1);
    end
    next_r.cnt = (AW+1)'(r.cnt + {AW'(0), push} - {AW'(0), pop});
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// ### ebl_i2c_engine.sv
// i2c master byte engine doing random reads, one byte per request
`timescale 1ns/1ps
`default_nettype none
module ebl_i2c_engine (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // timing and target
  input wire logic [15:0] quarter_div,
  input wire logic [6:0] dev_addr,
  input wire logic [15:0] byte_addr,
  // byte requests
  input wire logic req_valid,
  input wire logic req_last,
  output logic req_ready,
  output logic closed,
  output logic nack,
  // read bytes out
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  // synchronised pin levels and drives
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe_b,
  output logic sda_oe_b
);
  import ebl_pkg::*;
  typedef enum logic [2:0] {
    E_IDLE = 3'h0, E_START = 3'h1, E_WR = 3'h3, E_RD = 3'h2, E_STOP = 3'h6
  } ebl_eng_st_t;
  typedef struct packed {
    ebl_eng_st_t st;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [1:0] hdr;
    logic rs;
    logic open;
    logic last;
    logic nack;
    logic rd_valid;
    logic [7:0] rd_data;
    logic [15:0] div;
    logic scl_oe_b;
    logic sda_oe_b;
  } ebl_eng_t;
  ebl_eng_t r, next_r;
  logic tick, adv;
  assign req_ready = (r.st == E_IDLE) && !r.rd_valid;
  assign closed = (r.st == E_IDLE) && !r.open;
  assign nack = r.nack;
  assign rd_valid = r.rd_valid;
  assign rd_data = r.rd_data;
  assign scl_oe_b = r.scl_oe_b;
  assign sda_oe_b = r.sda_oe_b;
  assign tick = (r.div == 16'h0000);
  // hold the sample phase while a slave stretches scl low
  assign adv = tick && (r.st != E_IDLE) && !(r.q == Q_SAMPLE && !scl_in);
  always_comb begin
    next_r = r;
    if (r.rd_valid && rd_ready) next_r.rd_valid = 1'b0;
    next_r.div = tick ? quarter_div : 16'(r.div - 1'b1);
    if (adv) next_r.q = 2'(r.q + 1'b1);
    case (r.st)
      E_IDLE: begin
        next_r.div = quarter_div;
        next_r.q = Q_SETUP;
        if (req_valid && req_ready) begin
          next_r.last = req_last;
          next_r.bitn = 4'h0;
          next_r.rs = 1'b0;
          next_r.st = r.open ? E_RD : E_START;
        end
      end
      E_START: if (adv) begin
        // release sda, release scl, pull sda, pull scl
        case (r.q)
          Q_SETUP: next_r.sda_oe_b = 1'b1;
          Q_RISE: next_r.scl_oe_b = 1'b1;
          Q_SAMPLE: next_r.sda_oe_b = 1'b0;
          default: begin
            next_r.scl_oe_b = 1'b0;
            next_r.st = E_WR;
            next_r.bitn = 4'h0;
            next_r.sh = {dev_addr, r.rs, 1'b1};
            next_r.hdr = r.rs ? HDR_DEVR : HDR_DEVW;
          end
        endcase
      end
      E_WR: if (adv) begin
        case (r.q)
          Q_SETUP: next_r.sda_oe_b = r.sh[8];
          Q_RISE: next_r.scl_oe_b = 1'b1;
          Q_SAMPLE: if (r.bitn == ACK_BIT && sda_in) next_r.nack = 1'b1;
          default: begin
            next_r.scl_oe_b = 1'b0;
            next_r.sh = {r.sh[7:0], 1'b1};
            next_r.bitn = 4'(r.bitn + 1'b1);
            if (r.bitn == ACK_BIT) begin
              next_r.bitn = 4'h0;
              // address high, address low, repeated start, then reads
              case (r.hdr)
                HDR_DEVW: begin
                  next_r.sh = {byte_addr[15:8], 1'b1};
                  next_r.hdr = HDR_AHI;
                end
                HDR_AHI: begin
                  next_r.sh = {byte_addr[7:0], 1'b1};
                  next_r.hdr = HDR_ALO;
                end
                HDR_ALO: begin
                  next_r.st = E_START;
                  next_r.rs = 1'b1;
                end
                default: begin
                  next_r.st = E_RD;
                  next_r.open = 1'b1;
                end
              endcase
            end
          end
        endcase
      end
      E_RD: if (adv) begin
        case (r.q)
          Q_SETUP: next_r.sda_oe_b = (r.bitn == ACK_BIT) ? r.last : 1'b1;
          Q_RISE: next_r.scl_oe_b = 1'b1;
          Q_SAMPLE: if (r.bitn != ACK_BIT) next_r.sh = {r.sh[7:0], sda_in};
          default: begin
            next_r.scl_oe_b = 1'b0;
            next_r.bitn = 4'(r.bitn + 1'b1);
            if (r.bitn == ACK_BIT) begin
              next_r.st = r.last ? E_STOP : E_IDLE;
              // the nacked closing byte is thrown away
              if (!r.last) begin
                next_r.rd_valid = 1'b1;
                next_r.rd_data = r.sh[7:0];
              end
            end
          end
        endcase
      end
      E_STOP: if (adv) begin
        case (r.q)
          Q_SETUP: next_r.sda_oe_b = 1'b0;
          Q_RISE: next_r.scl_oe_b = 1'b1;
          Q_SAMPLE: next_r.sda_oe_b = 1'b1;
          default: begin
            next_r.st = E_IDLE;
            next_r.open = 1'b0;
          end
        endcase
      end
      default: next_r.st = E_IDLE;
    endcase
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r <= '0;
      r.scl_oe_b <= 1'b1;
      r.sda_oe_b <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// ### ebl_boot_loader.sv
// eeprom boot loader top: parameter blocks, boot configuration, boot table copy
`timescale 1ns/1ps
`default_nettype none
module ebl_boot_loader #(
  // bus timing used until the first parameter block sets its own
  parameter logic [15:0] START_QUARTER = ebl_pkg::DEF_QUARTER
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // block select straps
  input wire logic [2:0] param_block_select_pins,
  // i2c pins, oe low drives the line low
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_b,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b,
  // memory access
  output logic [31:0] mem_addr,
  output logic mem_wr_valid,
  output logic [31:0] mem_wr_data,
  input wire logic mem_wr_ready,
  output logic mem_rd_valid,
  input wire logic mem_rd_ready,
  input wire logic mem_rd_resp_valid,
  input wire logic [31:0] mem_rd_resp_data,
  // status
  output logic boot_busy,
  output logic boot_done,
  output logic boot_error,
  output logic [31:0] entry_addr
);
  import ebl_pkg::*;
  typedef enum logic [3:0] {
    M_PSTART = 4'h0, M_GET = 4'h1, M_PFLD = 4'h3, M_CLOSE = 4'h2,
    M_DIV = 4'h6, M_CFG_A = 4'h7, M_CFG_S = 4'h5, M_CFG_C = 4'h4,
    M_RMW_RD = 4'hc, M_WRITE = 4'hd, M_T_ENT = 4'hf, M_T_CNT = 4'he,
    M_T_DST = 4'ha, M_T_DAT = 4'hb, M_DONE = 4'h9, M_ERR = 4'h8
  } ebl_mst_t;
  typedef struct packed {
    ebl_mst_t st;
    ebl_mst_t ret;
    logic [2:0] pin_m;
    logic [2:0] pin_s;
    logic scl_m;
    logic scl_s;
    logic sda_m;
    logic sda_s;
    logic [1:0] wait_cnt;
    logic [2:0] want;
    logic [2:0] need;
    logic [31:0] acc;
    logic [4:0] ofs;
    logic [15:0] opts;
    logic [15:0] src_lo;
    logic [15:0] src_hi;
    logic [15:0] mhz;
    logic [15:0] khz;
    logic [15:0] nxt_lo;
    logic [15:0] nxt_hi;
    logic [6:0] dev;
    logic [15:0] baddr;
    logic [15:0] quarter;
    logic [15:0] quo;
    logic [31:0] num;
    logic [31:0] tgt;
    logic [31:0] setm;
    logic [31:0] dst;
    logic [31:0] remain;
    logic [31:0] entry;
    logic [31:0] maddr;
    logic [31:0] wr_data;
    logic wr_valid;
    logic rd_valid;
    logic busy;
    logic done;
    logic err;
  } ebl_main_t;
  ebl_main_t r, next_r;

  // engine and fifo wiring
  logic eng_req_valid, eng_req_last, eng_req_ready, eng_closed, eng_nack;
  logic byte_valid, byte_ready, fifo_valid, fifo_ready;
  logic [7:0] byte_data, fifo_data;
  logic [31:0] rmw_value;

  // schedule a fetch of k bytes, resuming at ret
  function automatic ebl_main_t get_bytes(ebl_main_t s, logic [2:0] k, ebl_mst_t ret);
    get_bytes = s;
    get_bytes.want = k;
    get_bytes.need = k;
    get_bytes.st = M_GET;
    get_bytes.ret = ret;
  endfunction

  // end the open read with a nacked dummy byte and a stop
  function automatic ebl_main_t close_to(ebl_main_t s, ebl_mst_t ret);
    close_to = s;
    close_to.want = 3'h1;
    close_to.st = M_CLOSE;
    close_to.ret = ret;
  endfunction

  ebl_i2c_engine u_engine (
    .clock(clock),
    .rst_b(rst_b),
    .quarter_div(r.quarter),
    .dev_addr(r.dev),
    .byte_addr(r.baddr),
    .req_valid(eng_req_valid),
    .req_last(eng_req_last),
    .req_ready(eng_req_ready),
    .closed(eng_closed),
    .nack(eng_nack),
    .rd_valid(byte_valid),
    .rd_ready(byte_ready),
    .rd_data(byte_data),
    .scl_in(r.scl_s),
    .sda_in(r.sda_s),
    .scl_oe_b(scl_oe_b),
    .sda_oe_b(sda_oe_b)
  );

  // a full fifo stalls the engine before it clocks in another byte
  ebl_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(byte_valid),
    .in_ready(byte_ready),
    .in_data(byte_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // requests are issued only from the fetch and close states
  assign eng_req_valid = (r.st == M_GET || r.st == M_CLOSE) && (r.want != 3'h0);
  assign eng_req_last = (r.st == M_CLOSE);
  assign fifo_ready = (r.st == M_GET) && (r.need != 3'h0);
  // set-only bits set, clear-only bits clear, bits in both toggle
  assign rmw_value = ((mem_rd_resp_data | (r.setm & ~r.acc)) & ~(r.acc & ~r.setm))
                     ^ (r.setm & r.acc);

  // outputs
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign mem_addr = r.maddr;
  assign mem_wr_valid = r.wr_valid;
  assign mem_wr_data = r.wr_data;
  assign mem_rd_valid = r.rd_valid;
  assign boot_busy = r.busy;
  assign boot_done = r.done;
  assign boot_error = r.err;
  assign entry_addr = r.entry;

  // sequencing: fetch, decode, then apply or copy
  always_comb begin
    next_r = r;
    // pin synchronisers
    next_r.pin_m = param_block_select_pins;
    next_r.pin_s = r.pin_m;
    next_r.scl_m = scl_in;
    next_r.scl_s = r.scl_m;
    next_r.sda_m = sda_in;
    next_r.sda_s = r.sda_m;
    if (eng_req_valid && eng_req_ready) next_r.want = 3'(r.want - 1'b1);
    case (r.st)
      M_PSTART: begin
        if (r.wait_cnt != SYNC_WAIT) begin
          // straps are re-read until the synchroniser has settled
          next_r.wait_cnt = 2'(r.wait_cnt + 1'b1);
          next_r.baddr = 16'(16'(r.pin_s) * BLOCK_STRIDE);
        end else begin
          next_r.ofs = 5'h00;
          next_r = get_bytes(next_r, HALF_BYTES, M_PFLD);
        end
      end

      // bytes shift in oldest first, so fields arrive big-endian
      M_GET: begin
        if (fifo_valid && fifo_ready) begin
          next_r.acc = {r.acc[23:0], fifo_data}; // most significant byte first
          next_r.need = 3'(r.need - 1'b1);
        end
        if (eng_nack) next_r.st = M_ERR;
        else if (r.need == 3'h0 && r.want == 3'h0) next_r.st = r.ret;
      end

      // the dummy byte is nacked so the eeprom frees sda
      M_CLOSE: begin
        if (r.want == 3'h0 && eng_closed) next_r.st = r.ret;
      end

      M_PFLD: begin
        case (r.ofs)
          OFS_OPTIONS: next_r.opts = r.acc[15:0];
          OFS_DEV_LO: next_r.src_lo = r.acc[15:0];
          OFS_DEV_HI: next_r.src_hi = r.acc[15:0];
          OFS_CPU_MHZ: next_r.mhz = r.acc[15:0];
          OFS_I2C_KHZ: next_r.khz = r.acc[15:0];
          OFS_NEXT_LO: next_r.nxt_lo = r.acc[15:0];
          OFS_NEXT_HI: next_r.nxt_hi = r.acc[15:0];
          default: next_r.ofs = r.ofs;
        endcase
        next_r.ofs = 5'(r.ofs + HALF_STEP);
        if (5'(r.ofs + HALF_STEP) == PARAM_BYTES) begin
          next_r.num = 32'(r.mhz) * KHZ_SCALE;
          next_r.quo = 16'h0000;
          next_r = close_to(next_r, M_DIV);
        end else begin
          next_r = get_bytes(next_r, HALF_BYTES, M_PFLD);
        end
      end

      M_DIV: begin
        // quarter period = mhz * 1000 / (4 * khz), by repeated subtraction
        if (r.khz != 16'h0000 && r.num >= 32'(r.khz)) begin
          next_r.num = r.num - 32'(r.khz);
          next_r.quo = 16'(r.quo + 1'b1);
        end else begin
          if (r.khz != 16'h0000) begin
            next_r.quarter = (r.quo == 16'h0000) ? 16'h0001 : r.quo;
          end
          next_r.dev = r.src_hi[6:0];
          next_r.baddr = r.src_lo;
          if (r.opts == OPT_TABLE) begin
            next_r = get_bytes(next_r, WORD_BYTES, M_T_ENT);
          end else if (r.opts == OPT_CFG) begin
            next_r = get_bytes(next_r, WORD_BYTES, M_CFG_A);
          end else begin
            next_r.st = M_ERR;
          end
        end
      end

      // configuration entries are three words each
      M_CFG_A: begin
        next_r.tgt = r.acc;
        next_r = get_bytes(next_r, WORD_BYTES, M_CFG_S);
      end
      M_CFG_S: begin
        next_r.setm = r.acc;
        next_r = get_bytes(next_r, WORD_BYTES, M_CFG_C);
      end
      M_CFG_C: begin
        if (r.tgt == 32'h0 && r.setm == 32'h0 && r.acc == 32'h0) begin
          next_r.dev = r.nxt_hi[6:0];
          next_r.baddr = r.nxt_lo;
          next_r.wait_cnt = SYNC_WAIT;
          next_r = close_to(next_r, M_PSTART);
        end else if (r.setm == 32'h0 && r.acc == 32'h0) begin
          // a call entry cannot run here; it is skipped
          next_r = get_bytes(next_r, WORD_BYTES, M_CFG_A);
        end else begin
          next_r.maddr = r.tgt;
          next_r.rd_valid = 1'b1;
          next_r.st = M_RMW_RD;
        end
      end

      // a response in the accept cycle counts too
      M_RMW_RD: begin
        if (r.rd_valid && mem_rd_ready) next_r.rd_valid = 1'b0;
        if (mem_rd_resp_valid && (!r.rd_valid || mem_rd_ready)) begin
          next_r.rd_valid = 1'b0;
          next_r.wr_data = rmw_value;
          next_r.wr_valid = 1'b1;
          next_r.st = M_WRITE;
        end
      end

      M_WRITE: begin
        if (mem_wr_ready) begin
          next_r.wr_valid = 1'b0;
          if (r.opts == OPT_CFG) begin
            next_r = get_bytes(next_r, WORD_BYTES, M_CFG_A);
          end else begin
            // sections are whole words, a short tail still costs one word
            next_r.dst = r.dst + WORD_STEP;
            next_r.remain = (r.remain <= WORD_STEP) ? 32'h0 : r.remain - WORD_STEP;
            if (r.remain <= WORD_STEP) begin
              next_r = get_bytes(next_r, WORD_BYTES, M_T_CNT);
            end else begin
              next_r = get_bytes(next_r, WORD_BYTES, M_T_DAT);
            end
          end
        end
      end

      // boot table: entry word, then count and destination
      M_T_ENT: begin
        next_r.entry = r.acc;
        next_r = get_bytes(next_r, WORD_BYTES, M_T_CNT);
      end
      M_T_CNT: begin
        if (r.acc == 32'h0) begin
          next_r = close_to(next_r, M_DONE);
        end else begin
          next_r.remain = r.acc;
          next_r = get_bytes(next_r, WORD_BYTES, M_T_DST);
        end
      end
      M_T_DST: begin
        next_r.dst = r.acc;
        next_r = get_bytes(next_r, WORD_BYTES, M_T_DAT);
      end
      M_T_DAT: begin
        next_r.maddr = r.dst;
        next_r.wr_data = r.acc;
        next_r.wr_valid = 1'b1;
        next_r.st = M_WRITE;
      end

      M_DONE: begin
        // terminal: hand over at the entry address, no further blocks
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
      M_ERR: begin
        next_r.busy = 1'b0;
        next_r.err = 1'b1;
      end
      default: next_r.st = M_ERR;
    endcase
  end

  // reset also restores the first bus timing
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r <= '0;
      r.st <= M_PSTART;
      r.ret <= M_PSTART;
      r.dev <= DEF_DEV;
      r.quarter <= START_QUARTER;
      r.busy <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// ### ebl_boot_props.sv
// port assertions for the eeprom boot loader
`timescale 1ns/1ps
`default_nettype none
module ebl_boot_props (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // watched ports
  input wire logic scl_oe_b,
  input wire logic sda_oe_b,
  input wire logic [31:0] mem_addr,
  input wire logic mem_wr_valid,
  input wire logic [31:0] mem_wr_data,
  input wire logic mem_wr_ready,
  input wire logic mem_rd_valid,
  input wire logic mem_rd_ready,
  input wire logic boot_busy,
  input wire logic boot_done,
  input wire logic boot_error,
  input wire logic [31:0] entry_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_wr_hold: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
    && $stable(mem_addr) && $stable(mem_wr_data)) else $error("write request dropped early");
  a_wr_single: assert property (mem_wr_valid && mem_wr_ready |=> !mem_wr_valid)
    else $error("write repeated after accept");
  a_rd_hold: assert property (mem_rd_valid && !mem_rd_ready |=> mem_rd_valid
    && $stable(mem_addr)) else $error("read request dropped early");
  a_rmw_serial: assert property (!(mem_rd_valid && mem_wr_valid))
    else $error("read and write both pending");
  a_done_quiet: assert property (boot_done |-> !mem_wr_valid && !mem_rd_valid
    && scl_oe_b && sda_oe_b) else $error("activity after boot done");
  a_done_final: assert property (boot_done |-> !boot_busy ##1 boot_done
    && $stable(entry_addr)) else $error("boot done not final");
  a_error_final: assert property (boot_error |=> boot_error && !boot_done)
    else $error("error state left");
  a_scl_phase: assert property ($changed(scl_oe_b) |=> $stable(scl_oe_b))
    else $error("scl phase shorter than two cycles");
endmodule
bind ebl_boot_loader ebl_boot_props i_props (.clock(clock), .rst_b(rst_b),
  .scl_oe_b(scl_oe_b), .sda_oe_b(sda_oe_b), .mem_addr(mem_addr),
  .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready),
  .mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready), .boot_busy(boot_busy),
  .boot_done(boot_done), .boot_error(boot_error), .entry_addr(entry_addr));
`default_nettype wire

// ### ebl_eeprom_model.sv
// behavioural serial eeprom: address writes, then sequential reads
`timescale 1ns/1ps
`default_nettype none
module ebl_eeprom_model #(
  parameter logic [6:0] DEV = 7'h50
) (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // data drive, 1 releases to the pull-up
  output logic sda_rel
);
  logic [7:0] mem [0:2047];
  logic [7:0] sh = 8'h00;
  logic [15:0] ptr = 16'h0000;
  logic act = 1'b0;
  logic rd = 1'b0;
  int bitn = 0;
  int ph = 0;
  initial sda_rel = 1'b1;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // start or repeated start restarts the header
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    rd = 1'b0;
    bitn = 0;
    ph = 0;
  end
  // stop idles the part
  always @(posedge sda) if (scl === 1'b1) act = 1'b0;
  // sample on rising scl; a master nack ends the read
  always @(posedge scl) if (act) begin
    if (bitn < 8 && !rd) sh = {sh[6:0], sda};
    if (bitn == 8 && rd && sda) act = 1'b0;
    bitn++;
  end
  // drive only while scl is low so no false start or stop appears
  always @(negedge scl) if (act) begin
    if (bitn == 8 && !rd) begin
      sda_rel = (ph == 0 && sh[7:1] != DEV);
      if (ph == 0) rd = sh[0];
      if (ph == 1) ptr[15:8] = sh;
      if (ph == 2) ptr[7:0] = sh;
      ph++;
    end else if (bitn == 8) sda_rel = 1'b1;
    else if (bitn == 9) begin
      bitn = 0;
      if (rd) sh = mem[ptr[10:0]];
      if (rd) ptr++;
      sda_rel = !rd | sh[7];
    end else if (rd) sda_rel = sh[7 - bitn];
  end
endmodule
`default_nettype wire

// ### testbench.sv
// boot loader bench: eeprom image, stalling memory, boot walks
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ebl_pkg::*;
  typedef struct {logic [31:0] a; logic [31:0] d;} ebl_row_t;
  logic clock, rst_b, sda_rel;
  logic [2:0] param_block_select_pins;
  logic scl_oe_b, sda_oe_b, mem_wr_valid, mem_wr_ready, mem_rd_valid, mem_rd_ready;
  logic mem_rd_resp_valid, boot_busy, boot_done, boot_error;
  logic [31:0] mem_addr, mem_wr_data, mem_rd_resp_data, entry_addr;
  logic [31:0] ram [0:31];
  ebl_row_t wr_seen [0:15];
  int nw = 0;
  int wst = 0;
  int err_total = 0;
  int n_checks = 0;
  // config at 0x400, then boot table at 0x100; last section padded to a word
  logic [31:0] img [0:18] = '{32'h10, 32'hffff_0000, 32'h0000_ffff, 32'h14, 32'h0101_0101,
    32'h0101_0101, 32'h0, 32'h0, 32'h0, 32'h1234, 32'h8, 32'h20, 32'ha1a2_a3a4,
    32'hb1b2_b3b4, 32'h5, 32'h40, 32'hc1c2_c3c4, 32'hc500_0000, 32'h0};
  ebl_row_t rows [0:5] = '{'{32'h10, 32'hffff_0000}, '{32'h14, 32'h01fe_01f1},
    '{32'h20, 32'ha1a2_a3a4}, '{32'h24, 32'hb1b2_b3b4}, '{32'h40, 32'hc1c2_c3c4},
    '{32'h44, 32'hc500_0000}};
  wire logic scl_w = scl_oe_b;
  wire logic sda_w = sda_oe_b & sda_rel;
  ebl_boot_loader #(.START_QUARTER(16'h0003)) i_dut (.clock(clock), .rst_b(rst_b),
    .param_block_select_pins(param_block_select_pins), .scl_in(scl_w), .scl_out(),
    .scl_oe_b(scl_oe_b), .sda_in(sda_w), .sda_out(), .sda_oe_b(sda_oe_b),
    .mem_addr(mem_addr), .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data),
    .mem_wr_ready(mem_wr_ready), .mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready),
    .mem_rd_resp_valid(mem_rd_resp_valid), .mem_rd_resp_data(mem_rd_resp_data),
    .boot_busy(boot_busy), .boot_done(boot_done), .boot_error(boot_error),
    .entry_addr(entry_addr));
  ebl_eeprom_model i_eep (.scl(scl_w), .sda(sda_w), .sda_rel(sda_rel));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // memory answers after a stall so the hold rules are exercised
  always @(negedge clock) begin
    mem_wr_ready <= 1'b0;
    mem_rd_ready <= 1'b0;
    mem_rd_resp_valid <= 1'b0;
    if ((mem_wr_valid | mem_rd_valid) === 1'b1 && !(mem_wr_ready | mem_rd_ready)) begin
      wst <= (wst == 2) ? 0 : wst + 1;
      if (wst == 2) begin
        mem_wr_ready <= mem_wr_valid;
        mem_rd_ready <= mem_rd_valid;
        mem_rd_resp_valid <= mem_rd_valid;
        mem_rd_resp_data <= ram[mem_addr[6:2]];
      end
    end
  end
  // record every accepted write
  always @(posedge clock) if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
    if (nw < 16) wr_seen[nw] = '{mem_addr, mem_wr_data};
    ram[mem_addr[6:2]] = mem_wr_data;
    nw++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic put16(input logic [15:0] a, input logic [15:0] v);
    i_eep.mem[a[10:0]] = v[15:8];
    i_eep.mem[a[10:0] + 11'h001] = v[7:0];
  endtask
  // parameter block: options, source, fast bus timing, next block
  task automatic blk(input logic [15:0] b, input logic [15:0] opt, input logic [15:0] src,
                     input logic [15:0] nxt);
    put16(b + 16'h0006, opt);
    put16(b + 16'h0008, src);
    put16(b + 16'h000a, {9'h000, DEF_DEV});
    put16(b + 16'h0010, 16'h0001);
    put16(b + 16'h0012, 16'h00fa);
    put16(b + 16'h0014, nxt);
    put16(b + 16'h0016, {9'h000, DEF_DEV});
  endtask
  // reset, check reset levels, then wait boot end under a bound
  task automatic boot(input logic [2:0] pins);
    int i;
    @(negedge clock);
    param_block_select_pins = pins;
    rst_b = 1'b0;
    repeat (10) @(negedge clock);
    chk({boot_busy, scl_oe_b, sda_oe_b, boot_done, boot_error}, 32'h1c);
    rst_b = 1'b1;
    for (i = 0; i < 40000 && !(boot_done === 1'b1 || boot_error === 1'b1); i++) begin
      @(negedge clock);
    end
    if (i == 40000) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  initial begin
    rst_b = 1'b0;
    param_block_select_pins = 3'h3;
    mem_wr_ready = 1'b0;
    mem_rd_ready = 1'b0;
    mem_rd_resp_valid = 1'b0;
    mem_rd_resp_data = 32'h0;
    #1;
    foreach (ram[k]) ram[k] = 32'h0;
    ram[4] = 32'h1234_5678;
    ram[5] = 32'h00ff_00f0;
    blk(16'h0000, 16'h0003, 16'h0000, 16'h0000);
    blk(16'h0180, OPT_CFG, 16'h0400, 16'h0080);
    blk(16'h0080, OPT_TABLE, 16'h0100, 16'h0000);
    for (int i = 0; i < 19; i++) begin
      put16((i < 9) ? 16'(16'h0400 + 4 * i) : 16'(16'h00dc + 4 * i), img[i][31:16]);
      put16((i < 9) ? 16'(16'h0402 + 4 * i) : 16'(16'h00de + 4 * i), img[i][15:0]);
    end
    boot(3'h3);
    chk(boot_done, 32'h1);
    chk(boot_error, 32'h0);
    chk(entry_addr, 32'h1234);
    chk(nw, 32'h6);
    for (int i = 0; i < 6; i++) begin
      chk(wr_seen[i].a, rows[i].a);
      chk(wr_seen[i].d, rows[i].d);
    end
    repeat (200) @(negedge clock);
    chk(nw, 32'h6);
    boot(3'h0);
    chk({boot_error, boot_done}, 32'h2);
    chk(nw, 32'h6);
    tally_and_finish();
  end
endmodule
`default_nettype wire
